// [core/boundary_scan_tap_logic.sv]
// Test access port controller with boundary register, config and analyzer paths
// Notes on behaviour
// - Standard TAP state machine and register behaviour.
// - Boundary scan blocked while configuration is busy.
// - Configuration words accepted through the port.
// - Sample captures pins, preload stores output pattern.
// - Analyzer capture has an instruction and register of its own.
// - Extest drives pattern, captures input pins.
// - Bypass is one bit, one clock delay.
// - User code is 32 bits shifted out.
// - Identification register shifted out serially.
// - Decode in-circuit reconfiguration instructions.
// - Decode analyzer readout instructions.
// - Largest variant: bypass and analyzer only.
`timescale 1ns/1ps

module boundary_scan_tap_logic import boundary_scan_pkg::*; #(
  parameter int PIN_COUNT = 8,
  parameter int CFG_WIDTH = 32,
  parameter int PROBE_WIDTH = 16,
  parameter bit LARGEST_VARIANT = 1'b0,
  // Arbitrary identification value; bit 0 must stay set
  parameter logic [ID_LEN-1:0] ID_CODE = 32'h0ABC_D001,
  parameter logic [USER_LEN-1:0] USER_CODE = 32'hFFFF_FFFF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEnable,
  input wire logic [PIN_COUNT-1:0] pinIn,
  input wire logic [PIN_COUNT-1:0] coreOut,
  input wire logic [PIN_COUNT-1:0] coreOe,
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOe,
  input wire logic configBusy,
  input wire logic [PROBE_WIDTH-1:0] probe,
  output logic cfgBegin,
  output logic cfgValid,
  output logic [CFG_WIDTH-1:0] cfgData
);
  localparam int BSR_LEN = CELLS_PER_PIN * PIN_COUNT;
  localparam int ANA_LEN = PROBE_WIDTH + 1;
  localparam int DR_W0 = (BSR_LEN > ID_LEN) ? BSR_LEN : ID_LEN;
  localparam int DR_W1 = (DR_W0 > CFG_WIDTH) ? DR_W0 : CFG_WIDTH;
  localparam int DR_W = (DR_W1 > ANA_LEN) ? DR_W1 : ANA_LEN;
  localparam int PUB_W = BSR_LEN + 1;
  localparam logic [IR_LEN-1:0] RESET_OP = LARGEST_VARIANT ? OP_BYPASS : OP_IDCODE;

  if (PIN_COUNT < 1 || CFG_WIDTH < 1 || PROBE_WIDTH < 1 || ID_CODE[0] != 1'b1) begin : gBadParam
    $error("boundary_scan_tap_logic: width below one or identification bit 0 clear");
  end
  typedef struct packed {
    tapState_e tap;
    logic [IR_LEN-1:0] ir;
    logic [IR_LEN-1:0] irShift;
    logic [DR_W-1:0] drShift;
    logic [BSR_LEN-1:0] updReg;
    logic extest;
    logic pubTgl;
    logic [CFG_WIDTH-1:0] cfgHold;
    logic cfgTgl;
    logic beginTgl;
    logic anaReqTgl;
    logic [1:0] busySync;
    logic [1:0] ackSync;
    logic [PIN_COUNT-1:0] pinSync1;
    logic [PIN_COUNT-1:0] pinSync2;
    logic [PIN_COUNT-1:0] outSync1;
    logic [PIN_COUNT-1:0] outSync2;
    logic [PIN_COUNT-1:0] oeSync1;
    logic [PIN_COUNT-1:0] oeSync2;
  } tckState_s;

  typedef struct packed {
    logic tdo;
    logic tdoEnable;
  } tdoState_s;

  typedef struct packed {
    logic [2:0] pubSync;
    logic [2:0] cfgSync;
    logic [2:0] beginSync;
    logic [2:0] reqSync;
    logic [PUB_W-1:0] pubCopy;
    logic [PROBE_WIDTH-1:0] probeHold;
    logic ackTgl;
    logic [PIN_COUNT-1:0] pinOut;
    logic [PIN_COUNT-1:0] pinOe;
    logic [CFG_WIDTH-1:0] cfgData;
    logic cfgValid;
    logic cfgBegin;
  } sysState_s;

  tckState_s t;
  tckState_s next_t;
  tdoState_s d;
  tdoState_s next_d;
  sysState_s s;
  sysState_s next_s;
  logic [1:0] sysRst;
  logic [1:0] tckRst;
  logic rstSysN;
  logic rstTckN;
  drSel_e sel;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions
  // standard TAP transitions
  function automatic tapState_e tapNext(input tapState_e st, input logic m);
    tapState_e r;
    r = st;
    unique case (st)
      TAP_RESET: r = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: r = m ? SELECT_DR : TAP_IDLE;
      SELECT_DR: r = m ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: r = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: r = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: r = m ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: r = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: r = m ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: r = m ? SELECT_DR : TAP_IDLE;
      SELECT_IR: r = m ? TAP_RESET : CAPTURE_IR;
      CAPTURE_IR: r = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: r = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: r = m ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: r = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: r = m ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: r = m ? SELECT_DR : TAP_IDLE;
    endcase
    return r;
  endfunction

  // Opcode to data register selection
  function automatic drSel_e decode(input logic [IR_LEN-1:0] op, input logic busy);
    drSel_e r;
    r = SEL_BYPASS;
    unique case (op)
      // largest variant keeps bypass and analyzer only
      OP_EXTEST, OP_SAMPLE: r = (busy || LARGEST_VARIANT) ? SEL_BYPASS : SEL_BOUND;
      OP_IDCODE: r = LARGEST_VARIANT ? SEL_BYPASS : SEL_ID;
      OP_USERCODE: r = LARGEST_VARIANT ? SEL_BYPASS : SEL_USER;
      OP_CFG_LOAD: r = LARGEST_VARIANT ? SEL_BYPASS : SEL_CFG;
      OP_ANA_READ: r = SEL_ANA;
      default: r = SEL_BYPASS;
    endcase
    return r;
  endfunction

  function automatic int drLen(input drSel_e sl);
    int r;
    r = BYPASS_LEN;
    unique case (sl)
      SEL_BOUND: r = BSR_LEN;
      SEL_ID: r = ID_LEN;
      SEL_USER: r = USER_LEN;
      SEL_CFG: r = CFG_WIDTH;
      SEL_ANA: r = ANA_LEN;
      SEL_BYPASS: r = BYPASS_LEN;
    endcase
    return r;
  endfunction

  // Serial shift toward bit 0, new bit enters at the selected length
  function automatic logic [DR_W-1:0] shiftIn(input logic [DR_W-1:0] cur, input logic bitIn, input int len);
    logic [DR_W-1:0] r;
    r = cur >> 1;
    r[len-1] = bitIn;
    return r;
  endfunction

  // pin snapshot, three cells per pin
  function automatic logic [BSR_LEN-1:0] pinSnapshot(input logic [PIN_COUNT-1:0] pi,
      input logic [PIN_COUNT-1:0] po, input logic [PIN_COUNT-1:0] pe);
    logic [BSR_LEN-1:0] r;
    r = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      r[CELLS_PER_PIN*i+CELL_IN] = pi[i];
      r[CELLS_PER_PIN*i+CELL_OUT] = po[i];
      r[CELLS_PER_PIN*i+CELL_OE] = pe[i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release in each domain
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sysRst <= 2'h0;
    end else begin
      sysRst <= {sysRst[0], 1'b1};
    end
  end
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      tckRst <= 2'h0;
    end else begin
      tckRst <= {tckRst[0], 1'b1};
    end
  end
  assign rstSysN = sysRst[1];
  assign rstTckN = tckRst[1];

  ////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by tck
  assign sel = decode(t.ir, t.busySync[1]);
  always_comb begin
    next_t = t;
    next_t.busySync = {t.busySync[0], configBusy};
    next_t.ackSync = {t.ackSync[0], s.ackTgl};
    next_t.pinSync1 = pinIn;
    next_t.pinSync2 = t.pinSync1;
    next_t.outSync1 = coreOut;
    next_t.outSync2 = t.outSync1;
    next_t.oeSync1 = coreOe;
    next_t.oeSync2 = t.oeSync1;
    next_t.tap = tapNext(t.tap, tms);
    unique case (t.tap)
      TAP_RESET: begin
        // default instruction, pins back to core
        next_t.ir = RESET_OP;
        next_t.extest = 1'b0;
        if (t.extest) begin
          next_t.pubTgl = ~t.pubTgl;
        end
      end
      CAPTURE_IR: next_t.irShift = IR_CAPTURE;
      SHIFT_IR: next_t.irShift = {tdi, t.irShift[IR_LEN-1:1]};
      UPDATE_IR: begin
        next_t.ir = t.irShift;
        next_t.extest = (t.irShift == OP_EXTEST) && (decode(t.irShift, t.busySync[1]) == SEL_BOUND);
        next_t.pubTgl = ~t.pubTgl;
        // start of configuration through the port
        if (t.irShift == OP_CFG_BEGIN && !LARGEST_VARIANT) begin
          next_t.beginTgl = ~t.beginTgl;
        end
        if (decode(t.irShift, t.busySync[1]) == SEL_ANA) begin
          next_t.anaReqTgl = ~t.anaReqTgl;
        end
      end
      CAPTURE_DR: begin
        unique case (sel)
          SEL_BOUND: next_t.drShift = DR_W'(pinSnapshot(t.pinSync2, t.outSync2, t.oeSync2));
          SEL_ID: next_t.drShift = DR_W'(ID_CODE);
          SEL_USER: next_t.drShift = DR_W'(USER_CODE);
          SEL_CFG: next_t.drShift = '0;
          SEL_ANA: next_t.drShift = DR_W'({t.ackSync[1] == t.anaReqTgl, s.probeHold});
          SEL_BYPASS: next_t.drShift = '0;
        endcase
      end
      SHIFT_DR: next_t.drShift = shiftIn(t.drShift, tdi, drLen(sel));
      UPDATE_DR: begin
        if (sel == SEL_BOUND) begin
          next_t.updReg = t.drShift[BSR_LEN-1:0];
          next_t.pubTgl = ~t.pubTgl;
        end
        if (sel == SEL_CFG) begin
          next_t.cfgHold = t.drShift[CFG_WIDTH-1:0];
          next_t.cfgTgl = ~t.cfgTgl;
        end
        if (sel == SEL_ANA) begin
          next_t.anaReqTgl = ~t.anaReqTgl;
        end
      end
      TAP_IDLE, SELECT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, SELECT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR: begin
      end
    endcase
  end

  always_ff @(posedge tck or negedge rstTckN) begin
    if (!rstTckN) begin
      t <= '0;
      t.tap <= TAP_RESET;
      t.ir <= RESET_OP;
    end else begin
      t <= next_t;
    end
  end

  // TDO changes on the falling edge
  always_comb begin
    next_d.tdoEnable = (t.tap == SHIFT_IR) || (t.tap == SHIFT_DR);
    next_d.tdo = 1'b0;
    if (t.tap == SHIFT_IR) begin
      next_d.tdo = t.irShift[0];
    end else if (t.tap == SHIFT_DR) begin
      next_d.tdo = t.drShift[0];
    end
  end

  always_ff @(negedge tck or negedge rstTckN) begin
    if (!rstTckN) begin
      d <= '0;
    end else begin
      d <= next_d;
    end
  end
  assign tdo = d.tdo;
  assign tdoEnable = d.tdoEnable;

  ////////////////////////////////////////////////////////////////////////////
  // System side, clocked by clk_sys
  always_comb begin
    logic extestOn;
    extestOn = 1'b0;
    next_s = s;
    next_s.pubSync = {s.pubSync[1:0], t.pubTgl};
    next_s.cfgSync = {s.cfgSync[1:0], t.cfgTgl};
    next_s.beginSync = {s.beginSync[1:0], t.beginTgl};
    next_s.reqSync = {s.reqSync[1:0], t.anaReqTgl};
    next_s.cfgValid = 1'b0;
    next_s.cfgBegin = 1'b0;
    if (s.pubSync[1] ^ s.pubSync[2]) begin
      next_s.pubCopy = {t.extest, t.updReg};
    end
    if (s.cfgSync[1] ^ s.cfgSync[2]) begin
      next_s.cfgData = t.cfgHold;
      next_s.cfgValid = 1'b1;
    end
    if (s.beginSync[1] ^ s.beginSync[2]) begin
      next_s.cfgBegin = 1'b1;
    end
    if (s.reqSync[1] ^ s.reqSync[2]) begin
      next_s.probeHold = probe;
      next_s.ackTgl = ~s.ackTgl;
    end
    // configuration in progress releases the pins
    extestOn = s.pubCopy[BSR_LEN] && !configBusy;
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_s.pinOut[i] = extestOn ? s.pubCopy[CELLS_PER_PIN*i+CELL_OUT] : coreOut[i];
      next_s.pinOe[i] = extestOn ? s.pubCopy[CELLS_PER_PIN*i+CELL_OE] : coreOe[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rstSysN) begin
    if (!rstSysN) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pinOut = s.pinOut;
  assign pinOe = s.pinOe;
  assign cfgData = s.cfgData;
  assign cfgValid = s.cfgValid;
  assign cfgBegin = s.cfgBegin;

endmodule

// [core/boundary_scan_pkg.sv]
// Shared constants and types of the test access port
package boundary_scan_pkg;

  localparam int IR_LEN = 4;
  localparam int ID_LEN = 32;
  localparam int USER_LEN = 32;
  localparam int BYPASS_LEN = 1;
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;

  localparam logic [IR_LEN-1:0] OP_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] OP_SAMPLE = 4'h1;
  localparam logic [IR_LEN-1:0] OP_IDCODE = 4'h6;
  localparam logic [IR_LEN-1:0] OP_USERCODE = 4'h7;
  localparam logic [IR_LEN-1:0] OP_CFG_BEGIN = 4'h8;
  localparam logic [IR_LEN-1:0] OP_CFG_LOAD = 4'h9;
  localparam logic [IR_LEN-1:0] OP_ANA_READ = 4'hC;
  localparam logic [IR_LEN-1:0] OP_BYPASS = 4'hF;

  // Fixed value loaded into the instruction shifter on capture
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;

  typedef enum logic [3:0] {
    TAP_RESET = 4'hF,
    TAP_IDLE = 4'hC,
    SELECT_DR = 4'h7,
    CAPTURE_DR = 4'h6,
    SHIFT_DR = 4'h2,
    EXIT1_DR = 4'h1,
    PAUSE_DR = 4'h3,
    EXIT2_DR = 4'h0,
    UPDATE_DR = 4'h5,
    SELECT_IR = 4'h4,
    CAPTURE_IR = 4'hE,
    SHIFT_IR = 4'hA,
    EXIT1_IR = 4'h9,
    PAUSE_IR = 4'hB,
    EXIT2_IR = 4'h8,
    UPDATE_IR = 4'hD
  } tapState_e;

  typedef enum logic [2:0] {
    SEL_BYPASS = 3'h0,
    SEL_BOUND = 3'h1,
    SEL_ID = 3'h2,
    SEL_USER = 3'h3,
    SEL_CFG = 3'h4,
    SEL_ANA = 3'h5
  } drSel_e;

endpackage

// [verification/boundary_scan_tap_logic_chk.sv]
// Port-level assertions of the test access port
`timescale 1ns/1ps
module boundary_scan_tap_logic_chk #(
  parameter int PIN_COUNT = 8,
  parameter int CFG_WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdoEnable,
  input wire logic [PIN_COUNT-1:0] coreOut,
  input wire logic [PIN_COUNT-1:0] coreOe,
  input wire logic [PIN_COUNT-1:0] pinOut,
  input wire logic [PIN_COUNT-1:0] pinOe,
  input wire logic configBusy,
  input wire logic cfgBegin,
  input wire logic cfgValid,
  input wire logic [CFG_WIDTH-1:0] cfgData
);
  chk_busy_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    configBusy && $past(resetn, 3) |=> pinOut == $past(coreOut)) else $error("pin level not core under busy");
  chk_busy_oe: assert property (@(posedge clk_sys) disable iff (!resetn)
    configBusy && $past(resetn, 3) |=> pinOe == $past(coreOe)) else $error("pin enable not core under busy");
  chk_valid_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfgValid |=> !cfgValid) else $error("config valid longer than one cycle");
  chk_data_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !cfgValid |-> $stable(cfgData)) else $error("config data moved without valid");
  chk_begin_pulse: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfgBegin |=> !cfgBegin) else $error("config begin longer than one cycle");
  chk_begin_alone: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfgBegin |-> !cfgValid) else $error("begin and word at once");
  chk_tdo_quiet: assert property (@(posedge tck) disable iff (!resetn)
    !tdoEnable |-> !tdo) else $error("serial out not low outside shift");
  chk_tdo_fall: assert property (@(posedge clk_sys) disable iff (!resetn)
    tck && $past(tck) |-> $stable({tdo, tdoEnable})) else $error("serial out moved while clock high");
  cover property (@(posedge clk_sys) cfgValid);
  cover property (@(posedge clk_sys) cfgBegin);
  cover property (@(posedge tck) $rose(tdoEnable));
endmodule

bind boundary_scan_tap_logic boundary_scan_tap_logic_chk #(.PIN_COUNT(PIN_COUNT), .CFG_WIDTH(CFG_WIDTH)) chk (
  .clk_sys, .resetn, .tck, .tdo, .tdoEnable, .coreOut, .coreOe, .pinOut, .pinOe,
  .configBusy, .cfgBegin, .cfgValid, .cfgData);

// [verification/jtag_host_model.sv]
// Behavioural scan host; clock stands low between steps
`timescale 1ns/1ps
module jtag_host_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic dIn, output logic q);
    tms = m;
    tdi = dIn;
    #40 tck = 1'b1;
    q = tdo;
    #40 tck = 1'b0;
  endtask
  // scan from idle back to idle
  task automatic scan(input bit ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = '0;
    step(1'b1, ~tdi, q);
    if (ir) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
  endtask
endmodule

// [verification/test_boundary_scan_tap_logic.sv]
// Self-checking bench of the test access port
`timescale 1ns/1ps
module test_boundary_scan_tap_logic import boundary_scan_pkg::*;;
  // Arbitrary code values
  localparam logic [31:0] IDV = 32'h1357_9BDF;
  localparam logic [31:0] UCV = 32'h2468_ACE0;
  localparam logic [7:0] WOUT = 8'h96;
  localparam logic [7:0] WOE = 8'hF0;
  logic clk_sys, resetn, tck, tms, tdi, tdo, tdoEnable, configBusy, cfgBegin, cfgValid, q;
  logic [7:0] pinIn, coreOut, coreOe, pinOut, pinOe;
  logic [15:0] probe;
  logic [31:0] cfgData;
  logic [63:0] d;
  logic [23:0] pat, cap;
  logic tck2, tms2, tdi2, tdo2, tdoEnable2, cfgBegin2, cfgValid2;
  logic [7:0] pinOut2, pinOe2;
  logic [31:0] cfgData2;
  int failures, check_count, cycles, beginCount, validCount, beginCount2;

  boundary_scan_tap_logic #(.ID_CODE(IDV), .USER_CODE(UCV)) dut (.clk_sys, .resetn, .tck, .tms, .tdi, .tdo,
    .tdoEnable, .pinIn, .coreOut, .coreOe, .pinOut, .pinOe, .configBusy, .probe, .cfgBegin, .cfgValid, .cfgData);
  jtag_host_model host (.tck, .tms, .tdi, .tdo);
  // Largest variant on a link of its own
  boundary_scan_tap_logic #(.LARGEST_VARIANT(1'b1)) dut2 (.clk_sys, .resetn, .tck(tck2), .tms(tms2), .tdi(tdi2),
    .tdo(tdo2), .tdoEnable(tdoEnable2), .pinIn, .coreOut, .coreOe, .pinOut(pinOut2), .pinOe(pinOe2), .configBusy,
    .probe, .cfgBegin(cfgBegin2), .cfgValid(cfgValid2), .cfgData(cfgData2));
  jtag_host_model host2 (.tck(tck2), .tms(tms2), .tdi(tdi2), .tdo(tdo2));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    cycles++;
    if (cfgBegin === 1'b1) beginCount++;
    if (cfgBegin2 === 1'b1) beginCount2++;
    if (cfgValid === 1'b1) validCount++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("failures=%0d checks=%0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic ir(input logic [3:0] op);
    host.scan(1'b1, 4, 64'(op), d);
  endtask
  task automatic pins(input logic [15:0] exp);
    repeat (8) @(negedge clk_sys);
    check(64'({pinOe, pinOut}), 64'(exp));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_ident();
    host.scan(1'b0, 32, 64'h0, d);
    check(d, 64'(IDV));
    ir(OP_USERCODE);
    check(d, 64'(IR_CAPTURE));
    host.scan(1'b0, 32, 64'h0, d);
    check(d, 64'(UCV));
    ir(OP_IDCODE);
    host.scan(1'b0, 32, 64'h0, d);
    check(d, 64'(IDV));
  endtask
  task automatic t_bypass();
    logic [3:0] ops [2];
    ops = '{OP_BYPASS, 4'h3};
    foreach (ops[k]) begin
      ir(ops[k]);
      host.scan(1'b0, 8, 64'hA5, d);
      check(d, 64'h4A);
    end
  endtask
  task automatic t_sample();
    for (int i = 0; i < 8; i++) begin
      cap[3*i +: 3] = {coreOe[i], coreOut[i], pinIn[i]};
      pat[3*i +: 3] = {WOE[i], WOUT[i], 1'b0};
    end
    ir(OP_SAMPLE);
    host.scan(1'b0, 24, 64'(pat), d);
    check(d, 64'(cap));
    pins({coreOe, coreOut});
  endtask
  task automatic t_extest();
    ir(OP_EXTEST);
    pins({WOE, WOUT});
    host.scan(1'b0, 24, 64'(pat), d);
    check(d, 64'(cap));
    @(negedge clk_sys) configBusy = 1'b1;
    pins({coreOe, coreOut});
    ir(OP_SAMPLE);
    host.scan(1'b0, 8, 64'hA5, d);
    check(d, 64'h4A);
    @(negedge clk_sys) configBusy = 1'b0;
    ir(OP_EXTEST);
    pins({WOE, WOUT});
    repeat (5) host.step(1'b1, ~tdi, q);
    host.step(1'b0, ~tdi, q);
    pins({coreOe, coreOut});
    host.scan(1'b0, 32, 64'h0, d);
    check(d, 64'(IDV));
  endtask
  task automatic t_cfg();
    ir(OP_CFG_BEGIN);
    repeat (8) @(negedge clk_sys);
    check(64'(beginCount), 64'h1);
    ir(OP_CFG_LOAD);
    host.scan(1'b0, 32, 64'h1234ABCD, d);
    repeat (8) @(negedge clk_sys);
    check(64'(cfgData), 64'h1234ABCD);
    check(64'(validCount), 64'h1);
  endtask
  task automatic t_ana();
    ir(OP_ANA_READ);
    repeat (4) host.step(1'b0, ~tdi, q);
    host.scan(1'b0, 17, 64'h0, d);
    check(d, 64'h1BEEF);
  endtask
  task automatic t_large();
    logic [63:0] e;
    repeat (5) host2.step(1'b1, 1'b0, q);
    host2.step(1'b0, 1'b0, q);
    host2.scan(1'b0, 8, 64'hA5, e);
    check(e, 64'h4A);
    host2.scan(1'b1, 4, 64'(OP_IDCODE), e);
    check(e, 64'(IR_CAPTURE));
    host2.scan(1'b0, 8, 64'hA5, e);
    check(e, 64'h4A);
    host2.scan(1'b1, 4, 64'(OP_CFG_BEGIN), e);
    repeat (8) @(negedge clk_sys);
    check(64'(beginCount2), 64'h0);
    host2.scan(1'b1, 4, 64'(OP_EXTEST), e);
    host2.scan(1'b0, 8, 64'hA5, e);
    check(e, 64'h4A);
    check(64'({pinOe2, pinOut2}), 64'({coreOe, coreOut}));
    host2.scan(1'b1, 4, 64'(OP_ANA_READ), e);
    repeat (4) host2.step(1'b0, 1'b0, q);
    host2.scan(1'b0, 17, 64'h0, e);
    check(e, 64'h1BEEF);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    configBusy = 1'b0;
    pinIn = 8'h5A;
    coreOut = 8'hC3;
    coreOe = 8'h0F;
    probe = 16'hBEEF;
    fork
      repeat (2) host.step(1'b1, ~tdi, q);
    join_none
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (5) host.step(1'b1, ~tdi, q);
    host.step(1'b0, ~tdi, q);
    t_ident();
    t_bypass();
    t_sample();
    t_extest();
    t_cfg();
    t_ana();
    t_large();
    close_out();
  end
endmodule
